// >>> hdl/dscg_map.svh
`ifndef DSCG_MAP_SVH
`define DSCG_MAP_SVH
// register byte offsets
`define DSCG_RUN_GATE1_OFF    12'h104
`define DSCG_SLEEP_GATE1_OFF  12'h114
`define DSCG_DEEP_GATE1_OFF   12'h124
`define DSCG_RUN_CFG_OFF      12'h060
`define DSCG_MODE_OFF         12'h200
`define DSCG_IRQ_STAT_OFF     12'h204
`define DSCG_IRQ_MASK_OFF     12'h208
`define DSCG_FAULT_UNIT_OFF   12'h20C
// gate field positions
`define DSCG_ASER0_BIT        0
`define DSCG_ASER1_BIT        1
`define DSCG_SSER0_BIT        4
`define DSCG_GPC0_BIT         16
`define DSCG_GPC1_BIT         17
`define DSCG_GPC2_BIT         18
`define DSCG_ACMP0_BIT        24
// writable bits of a gate register
`define DSCG_GATE_WMASK       32'h0107_0013
// auto gating select in run clock config
`define DSCG_AUTO_GATE_BIT    27
// reset values
`define DSCG_GATE_RST         32'h0000_0000
`define DSCG_CFG_RST          32'h0000_0000
// interrupt status bits
`define DSCG_IRQ_FAULT_BIT    0
`define DSCG_IRQ_MODE_BIT     1
`define DSCG_IRQ_WIDTH        2
`endif

// >>> hdl/dscg_pkg.sv
package dscg_pkg;
    // power mode of the system
    typedef enum logic [1:0] {
        DSCG_RUN,
        DSCG_SLEEP,
        DSCG_DEEP
    } dscg_mode_t;
    // register file bus states
    typedef enum logic [1:0] {
        DSCG_W_IDLE,
        DSCG_W_RESP
    } dscg_wstate_t;
endpackage : dscg_pkg

// >>> hdl/dscg_gate_sel.sv
`timescale 1ns/10ps
`include "dscg_map.svh"
// ----------------------------------------------------------------
// gate selector: picks the active gate set
// ----------------------------------------------------------------
module dscg_gate_sel
    import dscg_pkg::*;
#(
    parameter int unsigned W = 32
) (
    input  wire logic [W-1:0] run_gate,
    input  wire logic [W-1:0] sleep_gate,
    input  wire logic [W-1:0] deep_gate,
    input  wire logic         auto_gate,
    input  wire dscg_mode_t   mode,
    output logic [W-1:0]      gate_en
);
    // sleep/deep sets only count with auto gating; else run set holds
    always_comb begin
        gate_en = run_gate;
        if (auto_gate) begin
            case (mode)
                DSCG_SLEEP: gate_en = sleep_gate;
                DSCG_DEEP:  gate_en = deep_gate;
                default:    gate_en = run_gate;
            endcase
        end
    end
endmodule : dscg_gate_sel

// >>> hdl/dscg_fault_chk.sv
`timescale 1ns/10ps
`include "dscg_map.svh"
// ----------------------------------------------------------------
// fault checker: flags accesses to unclocked units
// ----------------------------------------------------------------
module dscg_fault_chk
    import dscg_pkg::*;
#(
    parameter int unsigned W = 32
) (
    input  wire logic [W-1:0] gate_en,
    input  wire logic [W-1:0] unit_sel,
    input  wire logic         unit_access,
    output logic              unit_fault
);
    // any selected unit at a writable gate bit with its gate clear faults the access
    always_comb begin
        unit_fault = unit_access && ((unit_sel & ~gate_en
                     & `DSCG_GATE_WMASK) != '0);
    end
endmodule : dscg_fault_chk

// >>> hdl/dscg_top.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "dscg_map.svh"
module dscg_top
    import dscg_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // system power mode, sampled every cycle
    input  wire dscg_mode_t  sys_mode,
    // peripheral access check: one-hot unit select in gate layout
    input  wire logic [31:0] unit_sel,
    input  wire logic        unit_access,
    output logic             unit_fault,
    // clock enables to gated units, and the interrupt output
    output logic             gp_counter_0_gate,
    output logic             gp_counter_1_gate,
    output logic             gp_counter_2_gate,
    output logic             analog_comparator_0_gate,
    output logic             sync_serial_0_gate,
    output logic             async_serial_0_gate,
    output logic             async_serial_1_gate,
    output logic             irq
);
    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [31:0]  run_clock_gate_1_r;         // run mode gates
    logic [31:0]  sleep_clock_gate_1_r;       // sleep mode gates
    logic [31:0]  deep_sleep_clock_gate_1_r;  // deep-sleep gates
    logic [31:0]  run_clock_config_r;         // holds auto gating select
    logic [31:0]  irq_stat_r;                 // sticky events
    logic [31:0]  irq_mask_r;                 // interrupt enables
    logic [31:0]  fault_unit_r;               // last faulting unit select
    dscg_mode_t   mode_r;                     // previous power mode
    logic [31:0]  gate_en;                    // active gate set
    logic         auto_gating_select;         // auto gating enable
    // write channel holding
    logic         aw_held_r;
    logic         w_held_r;
    logic [11:0]  awaddr_r;
    logic [31:0]  wdata_r;
    logic [3:0]   wstrb_r;
    logic         wr_fire;
    // read channel
    logic         rd_fire;
    // interrupt status update terms
    logic [31:0]  irq_clr;                    // write-one-to-clear bits
    logic [31:0]  irq_set;                    // events of this cycle

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // merge write data by byte strobes, keep only writable bits
    function automatic logic [31:0] dscg_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb,
                                               input logic [31:0] wmask);
        logic [31:0] bmask;
        bmask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old_v & ~bmask) | (new_v & bmask);
    endfunction : dscg_merge

    // known register offset check
    function automatic logic dscg_mapped(input logic [11:0] a);
        case ({a[11:2], 2'b00})
            `DSCG_RUN_GATE1_OFF, `DSCG_SLEEP_GATE1_OFF, `DSCG_DEEP_GATE1_OFF,
            `DSCG_RUN_CFG_OFF, `DSCG_MODE_OFF, `DSCG_IRQ_STAT_OFF,
            `DSCG_IRQ_MASK_OFF, `DSCG_FAULT_UNIT_OFF: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : dscg_mapped

    // ----------------------------------------------------------------
    // gate selection and fault check
    // ----------------------------------------------------------------
    // without auto gating the run set applies in every mode
    // units see their enable change in the same cycle as the mode
    assign auto_gating_select = run_clock_config_r[`DSCG_AUTO_GATE_BIT];

    dscg_gate_sel #(
        .W (32)
    ) u_sel (
        .run_gate   (run_clock_gate_1_r),
        .sleep_gate (sleep_clock_gate_1_r),
        .deep_gate  (deep_sleep_clock_gate_1_r),
        .auto_gate  (auto_gating_select),
        .mode       (sys_mode),
        .gate_en    (gate_en)
    );

    dscg_fault_chk #(
        .W (32)
    ) u_fault (
        .gate_en     (gate_en),
        .unit_sel    (unit_sel),
        .unit_access (unit_access),
        .unit_fault  (unit_fault)
    );

    // clock enables follow the active gate set
    always_comb begin
        async_serial_0_gate      = gate_en[`DSCG_ASER0_BIT];
        async_serial_1_gate      = gate_en[`DSCG_ASER1_BIT];
        sync_serial_0_gate       = gate_en[`DSCG_SSER0_BIT];
        gp_counter_0_gate        = gate_en[`DSCG_GPC0_BIT];
        gp_counter_1_gate        = gate_en[`DSCG_GPC1_BIT];
        gp_counter_2_gate        = gate_en[`DSCG_GPC2_BIT];
        analog_comparator_0_gate = gate_en[`DSCG_ACMP0_BIT];
    end

    // ----------------------------------------------------------------
    // axi write channel
    // ----------------------------------------------------------------
    // ready drops while an answer waits, so a second write cannot
    // overtake the response of the first
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
    assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;

    // capture address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 12'h000;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // write response, slverr on unmapped offset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= dscg_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // gate and config registers
    // ----------------------------------------------------------------
    // reserved bits never take data, so they read back zero and a
    // read-modify-write by software keeps them zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_clock_gate_1_r        <= `DSCG_GATE_RST;
            sleep_clock_gate_1_r      <= `DSCG_GATE_RST;
            deep_sleep_clock_gate_1_r <= `DSCG_GATE_RST;
            run_clock_config_r        <= `DSCG_CFG_RST;
            irq_mask_r                <= 32'h0000_0000;
        end else if (wr_fire) begin
            // only writable fields take data; reserved stay zero
            case ({awaddr_r[11:2], 2'b00})
                `DSCG_RUN_GATE1_OFF: run_clock_gate_1_r <= dscg_merge(
                    run_clock_gate_1_r, wdata_r, wstrb_r, `DSCG_GATE_WMASK);
                `DSCG_SLEEP_GATE1_OFF: sleep_clock_gate_1_r <= dscg_merge(
                    sleep_clock_gate_1_r, wdata_r, wstrb_r, `DSCG_GATE_WMASK);
                `DSCG_DEEP_GATE1_OFF: deep_sleep_clock_gate_1_r <= dscg_merge(
                    deep_sleep_clock_gate_1_r, wdata_r, wstrb_r,
                    `DSCG_GATE_WMASK);
                `DSCG_RUN_CFG_OFF: run_clock_config_r <= dscg_merge(
                    run_clock_config_r, wdata_r, wstrb_r,
                    32'h0800_0000);
                `DSCG_IRQ_MASK_OFF: irq_mask_r <= dscg_merge(
                    irq_mask_r, wdata_r, wstrb_r, 32'h0000_0003);
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // events and interrupt
    // ----------------------------------------------------------------
    // a mode change is an event; a fault is logged the edge after it
    // previous mode for change detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= DSCG_RUN;
        end else begin
            mode_r <= sys_mode;
        end
    end

    // sticky status terms: events of this cycle and software clears
    always_comb begin
        irq_clr = 32'h0000_0000;
        irq_set = 32'h0000_0000;
        if (wr_fire && ({awaddr_r[11:2], 2'b00} == `DSCG_IRQ_STAT_OFF)) begin
            irq_clr = dscg_merge(32'h0000_0000, wdata_r, wstrb_r, 32'h0000_0003);
        end
        irq_set[`DSCG_IRQ_FAULT_BIT] = unit_fault;
        irq_set[`DSCG_IRQ_MODE_BIT]  = (sys_mode != mode_r);
    end

    // sticky status, set wins over write-one-to-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= 32'h0000_0000;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    // last faulting unit select for software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_unit_r <= 32'h0000_0000;
        end else if (unit_fault) begin
            fault_unit_r <= unit_sel & `DSCG_GATE_WMASK;
        end
    end

    // level interrupt while any unmasked status bit is set
    assign irq = (irq_stat_r & irq_mask_r) != 32'h0000_0000;

    // ----------------------------------------------------------------
    // axi read channel
    // ----------------------------------------------------------------
    // one read at a time: arready stays low while the answer waits
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;

    // read data registered, reserved bits read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case ({s_axi_araddr[11:2], 2'b00})
                `DSCG_RUN_GATE1_OFF:   s_axi_rdata <= run_clock_gate_1_r;
                `DSCG_SLEEP_GATE1_OFF: s_axi_rdata <= sleep_clock_gate_1_r;
                `DSCG_DEEP_GATE1_OFF:  s_axi_rdata <= deep_sleep_clock_gate_1_r;
                `DSCG_RUN_CFG_OFF:     s_axi_rdata <= run_clock_config_r;
                `DSCG_MODE_OFF:        s_axi_rdata <= {30'h0, sys_mode};
                `DSCG_IRQ_STAT_OFF:    s_axi_rdata <= irq_stat_r;
                `DSCG_IRQ_MASK_OFF:    s_axi_rdata <= irq_mask_r;
                `DSCG_FAULT_UNIT_OFF:  s_axi_rdata <= fault_unit_r;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : dscg_top

// >>> dv/dscg_top_chk.sv
`timescale 1ns/10ps
`include "dscg_map.svh"
// ----------------------------------------
// port checker for the clock gate block
// ----------------------------------------
module dscg_top_chk
    import dscg_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire dscg_mode_t  sys_mode,
    input wire logic [31:0] unit_sel,
    input wire logic        unit_access,
    input wire logic        unit_fault,
    input wire logic        gp_counter_0_gate,
    input wire logic        gp_counter_1_gate,
    input wire logic        gp_counter_2_gate,
    input wire logic        analog_comparator_0_gate,
    input wire logic        sync_serial_0_gate,
    input wire logic        async_serial_0_gate,
    input wire logic        async_serial_1_gate,
    input wire logic        irq
);
    // every check runs on the bus clock and rests in reset
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [6:0] gates;  // all clock enables side by side
    assign gates = {gp_counter_0_gate, gp_counter_1_gate, gp_counter_2_gate,
                    analog_comparator_0_gate, sync_serial_0_gate,
                    async_serial_0_gate, async_serial_1_gate};
    chk_reset_gates: assert property ($rose(aresetn) |-> gates == 7'h00 && !irq)
        else $error("clock enable or irq high after reset");
    chk_idle_fault: assert property (!unit_access |-> !unit_fault)
        else $error("fault without access");
    chk_counter_fault: assert property (unit_access && unit_sel == 32'h0002_0000
        |-> unit_fault == !gp_counter_1_gate) else $error("counter 1 fault wrong");
    chk_serial_fault: assert property (unit_access && unit_sel == 32'h0000_0001
        |-> unit_fault == !async_serial_0_gate) else $error("serial 0 fault wrong");
    chk_rsvd_fault: assert property (unit_access && (unit_sel & `DSCG_GATE_WMASK) == 0
        |-> !unit_fault) else $error("fault on reserved unit");
    chk_gate_cause: assert property ($rose(gp_counter_0_gate)
        |-> $changed(sys_mode) || s_axi_bvalid || $past(s_axi_wvalid))
        else $error("enable rose without cause");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during answer");
endmodule : dscg_top_chk
bind dscg_top dscg_top_chk chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wvalid, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sys_mode,
    .unit_sel, .unit_access, .unit_fault, .gp_counter_0_gate, .gp_counter_1_gate,
    .gp_counter_2_gate, .analog_comparator_0_gate, .sync_serial_0_gate,
    .async_serial_0_gate, .async_serial_1_gate, .irq);

// >>> dv/tb.sv
`timescale 1ns/10ps
`include "dscg_map.svh"
module tb
    import dscg_pkg::*;
;
    // ----------------------------------------
    // signals and model state
    // ----------------------------------------
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, unit_access, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, unit_fault, irq;
    logic        gp_counter_0_gate, gp_counter_1_gate, gp_counter_2_gate;
    logic        analog_comparator_0_gate, sync_serial_0_gate;
    logic        async_serial_0_gate, async_serial_1_gate;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, unit_sel, en_v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    dscg_mode_t  sys_mode;
    int          error_cnt, cmp_count;
    int          gate_m[3];  // model gate sets: run, sleep, deep
    bit          auto_m;     // model auto gating select
    logic [11:0] offs[3] = '{`DSCG_RUN_GATE1_OFF, `DSCG_SLEEP_GATE1_OFF, `DSCG_DEEP_GATE1_OFF};
    // enables placed back at their gate bit positions
    assign en_v = {7'h0, analog_comparator_0_gate, 5'h0, gp_counter_2_gate, gp_counter_1_gate,
                   gp_counter_0_gate, 11'h0, sync_serial_0_gate, 2'h0, async_serial_1_gate,
                   async_serial_0_gate};
    dscg_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sys_mode, .unit_sel, .unit_access, .unit_fault,
        .gp_counter_0_gate, .gp_counter_1_gate, .gp_counter_2_gate, .analog_comparator_0_gate,
        .sync_serial_0_gate, .async_serial_0_gate, .async_serial_1_gate, .irq);
    // free running bus clock
    always #5 aclk = ~aclk;
    // ----------------------------------------
    // model, compares and bus tasks
    // ----------------------------------------
    // active gate set for a mode
    function automatic logic [31:0] act_m(dscg_mode_t m);
        if (auto_m && m == DSCG_SLEEP) return gate_m[1];
        if (auto_m && m == DSCG_DEEP) return gate_m[2];
        return gate_m[0];
    endfunction : act_m
    // byte lane merge of a write
    function automatic int merge(int o, logic [31:0] d, logic [3:0] s);
        for (int i = 0; i < 4; i++) if (s[i]) o[8*i +: 8] = d[8*i +: 8];
        return o;
    endfunction : merge
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic tmo;
        error_cnt++;
        $display("wrong value at %0t: timeout got %h exp %h", $time, 1'b0, 1'b1);
        end_sim();
    endtask : tmo
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk_word
    task automatic chk_flag(input logic g, input logic e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk_flag
    // write one word; handshakes judged on values that stand at the next rise
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int   n;
        logic ha, hw, hb, bv;
        logic [1:0] r;
        s_axi_bready <= 1'($urandom);  // a late bready exercises the answer hold
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        hb = 1'b0;
        n = 0;
        while (!hb) begin
            @(negedge aclk);
            ha = s_axi_awvalid & s_axi_awready;
            hw = s_axi_wvalid & s_axi_wready;
            hb = s_axi_bvalid & s_axi_bready;
            bv = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (bv && !s_axi_bready) s_axi_bready <= 1'b1;
            if (++n > 50) tmo();
        end
        chk_word({30'h0, r}, {30'h0, er});
        // model follows only accepted writes
        case (a)
            `DSCG_RUN_GATE1_OFF: gate_m[0] = merge(gate_m[0], d, s) & `DSCG_GATE_WMASK;
            `DSCG_SLEEP_GATE1_OFF: gate_m[1] = merge(gate_m[1], d, s) & `DSCG_GATE_WMASK;
            `DSCG_DEEP_GATE1_OFF: gate_m[2] = merge(gate_m[2], d, s) & `DSCG_GATE_WMASK;
            `DSCG_RUN_CFG_OFF: if (s[3]) auto_m = d[`DSCG_AUTO_GATE_BIT];
            default: ;
        endcase
    endtask : wr
    // read one word and compare data and response
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int   n;
        logic ha, hr, rv;
        logic [31:0] d;
        logic [1:0]  r;
        s_axi_rready <= 1'($urandom);  // a late rready exercises the data hold
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        hr = 1'b0;
        n = 0;
        while (!hr) begin
            @(negedge aclk);
            ha = s_axi_arvalid & s_axi_arready;
            hr = s_axi_rvalid & s_axi_rready;
            rv = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'b0;
            if (rv && !s_axi_rready) s_axi_rready <= 1'b1;
            if (++n > 50) tmo();
        end
        chk_word(d, ed);
        chk_word({30'h0, r}, {30'h0, er});
    endtask : rd_chk
    // irq level checked mid cycle
    task automatic see_irq(input logic e);
        @(negedge aclk);
        chk_flag(irq, e);
        @(posedge aclk);
    endtask : see_irq
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, unit_access} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, unit_sel} = '0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        sys_mode = DSCG_RUN;
        void'($urandom(32'h27cd));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 3; i++) rd_chk(offs[i], 32'h0, 2'b00);
        rd_chk(`DSCG_RUN_CFG_OFF, 32'h0, 2'b00);
        chk_word(en_v, 32'h0);
        $display("test reset done");
        // software enables the units it needs first
        wr(`DSCG_DEEP_GATE1_OFF, 32'hFFFF_FFFF, 4'hF, 2'b00);
        rd_chk(`DSCG_DEEP_GATE1_OFF, `DSCG_GATE_WMASK, 2'b00);
        for (int i = 0; i < 12; i++) begin
            wr(offs[i%3], $urandom, 4'($urandom), 2'b00);
            rd_chk(offs[i%3], gate_m[i%3], 2'b00);
        end
        $display("test gate registers done");
        for (int g = 0; g < 2; g++) begin
            wr(`DSCG_RUN_CFG_OFF, $urandom & 32'hF7FF_FFFF | (g << 27), 4'hF, 2'b00);
            rd_chk(`DSCG_RUN_CFG_OFF, {4'h0, auto_m, 27'h0}, 2'b00);
            for (int m = 0; m < 4; m++) begin
                sys_mode <= dscg_mode_t'(m[1:0]);
                @(negedge aclk);
                chk_word(en_v, act_m(sys_mode) & `DSCG_GATE_WMASK);
                for (int b = 0; b < 32; b++) begin
                    @(posedge aclk);
                    unit_sel <= 32'h1 << b;
                    unit_access <= 1'b1;
                    @(negedge aclk);
                    chk_flag(unit_fault,
                             |(unit_sel & `DSCG_GATE_WMASK & ~act_m(sys_mode)));
                end
                @(posedge aclk);
                unit_access <= 1'b0;
                rd_chk(`DSCG_MODE_OFF, 32'(m), 2'b00);
            end
        end
        $display("test modes and faults done");
        wr(`DSCG_RUN_GATE1_OFF, 32'h0, 4'hF, 2'b00);
        wr(`DSCG_IRQ_STAT_OFF, 32'h3, 4'hF, 2'b00);
        wr(`DSCG_IRQ_MASK_OFF, 32'h1, 4'hF, 2'b00);
        rd_chk(`DSCG_IRQ_STAT_OFF, 32'h0, 2'b00);
        see_irq(1'b0);
        unit_sel <= 32'h0000_0010;
        unit_access <= 1'b1;
        @(posedge aclk);
        unit_access <= 1'b0;
        see_irq(1'b1);
        rd_chk(`DSCG_IRQ_STAT_OFF, 32'h1, 2'b00);
        rd_chk(`DSCG_FAULT_UNIT_OFF, 32'h10, 2'b00);
        wr(`DSCG_IRQ_MASK_OFF, 32'h0, 4'hF, 2'b00);
        see_irq(1'b0);
        wr(`DSCG_IRQ_MASK_OFF, 32'h1, 4'hF, 2'b00);
        see_irq(1'b1);
        wr(`DSCG_IRQ_STAT_OFF, 32'h1, 4'hF, 2'b00);
        see_irq(1'b0);
        rd_chk(`DSCG_IRQ_STAT_OFF, 32'h0, 2'b00);
        // leaving the unused mode code is a mode change event
        wr(`DSCG_IRQ_MASK_OFF, 32'h2, 4'hF, 2'b00);
        sys_mode <= DSCG_RUN;
        @(posedge aclk);
        see_irq(1'b1);
        rd_chk(`DSCG_IRQ_STAT_OFF, 32'h2, 2'b00);
        $display("test interrupt done");
        wr(12'h300, $urandom, 4'hF, 2'b10);
        rd_chk(12'h300, 32'h0, 2'b10);
        $display("test unmapped done");
        end_sim();
    end
endmodule : tb
